/* shared/leir_regs.svh */
// Register map and field constants for the line event interrupt registers
// Behaviour
// - Writing one clears that pending flag
// - Flag reads one while its interrupt pends
// - Tone and ring timer flags in bits 5..0
// - Power alarm six..one flags in bits 7..2
// - Bit 1 latches loop closure transitions
// - Bit 0 latches ring trip events
// - Indirect done flag holds until written one
// - Tone/ring enables at bits 5..0, one enables
// - Power alarm enables at bits 7..2
// - Loop closure enable bit 1, ring trip bit 0
// - Reset clears all flags and enables
// - Third enable bit 1 gates indirect done
`ifndef LEIR_REGS_SVH
`define LEIR_REGS_SVH

`define LEIR_DATA_W          8
`define LEIR_IDX_W           6
`define LEIR_IDX_LSB         2
`define LEIR_TR_W            6
`define LEIR_AL_W            8
`define LEIR_IN_W            1

`define LEIR_IDX_PEND_TR     6'h12
`define LEIR_IDX_PEND_AL     6'h13
`define LEIR_IDX_PEND_IN     6'h14
`define LEIR_IDX_EN_TR       6'h15
`define LEIR_IDX_EN_AL       6'h16
`define LEIR_IDX_EN_IN       6'h17

`define LEIR_TR_RING_OFF     5
`define LEIR_TR_RING_ON      4
`define LEIR_TR_TWO_OFF      3
`define LEIR_TR_TWO_ON       2
`define LEIR_TR_ONE_OFF      1
`define LEIR_TR_ONE_ON       0

`define LEIR_AL_SIX          7
`define LEIR_AL_FIVE         6
`define LEIR_AL_FOUR         5
`define LEIR_AL_THREE        4
`define LEIR_AL_TWO          3
`define LEIR_AL_ONE          2
`define LEIR_AL_HOOK         1
`define LEIR_AL_RING_ANSWER  0

`define LEIR_IN_DONE         1

`define LEIR_RST_TR          6'h00
`define LEIR_RST_AL          8'h00
`define LEIR_RST_IN          1'h0
`define LEIR_RST_BYTE        8'h00
`define LEIR_ZERO_BYTE       8'h00
`define LEIR_ZERO_UPPER      24'h000000

`endif

/* shared/leir_pkg.sv */
// Types shared by the line event interrupt register block
`include "leir_regs.svh"

package leir_pkg;

    typedef logic [`LEIR_TR_W-1:0]   leir_tr_t;
    typedef logic [`LEIR_AL_W-1:0]   leir_al_t;
    typedef logic [`LEIR_IN_W-1:0]   leir_in_t;
    typedef logic [`LEIR_DATA_W-1:0] leir_byte_t;

    typedef struct packed {
        leir_tr_t   en_tr;
        leir_al_t   en_al;
        leir_in_t   en_in;
        logic       ack;
        leir_byte_t rdat;
        logic       irq;
    } leir_state_t;

endpackage : leir_pkg

/* rtl/leir_flag_bank.sv */
// Bank of sticky pending flags with write-one-to-clear
`timescale 1ns/1ps

module leir_flag_bank #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    output logic      [W-1:0] flags_o
);

    typedef struct packed {
        logic [W-1:0] flags;
    } leir_bank_state_t;

    leir_bank_state_t st;
    leir_bank_state_t next_st;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.flags = (st.flags & ~clr_i) | set_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.flags <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign flags_o = st.flags;

endmodule : leir_flag_bank

/* rtl/leir_top.sv */
// Line event interrupt pending and enable registers on classic Wishbone
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`include "leir_regs.svh"

module leir_top
    import leir_pkg::*;
#(
    parameter int ADR_W = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             ring_cadence_off_evt_i,
    input  wire logic             ring_cadence_on_evt_i,
    input  wire logic             tone_gen_two_off_evt_i,
    input  wire logic             tone_gen_two_on_evt_i,
    input  wire logic             tone_gen_one_off_evt_i,
    input  wire logic             tone_gen_one_on_evt_i,
    input  wire logic             power_alarm_six_evt_i,
    input  wire logic             power_alarm_five_evt_i,
    input  wire logic             power_alarm_four_evt_i,
    input  wire logic             power_alarm_three_evt_i,
    input  wire logic             power_alarm_two_evt_i,
    input  wire logic             power_alarm_one_evt_i,
    input  wire logic             hook_change_evt_i,
    input  wire logic             ring_answer_evt_i,
    input  wire logic             indirect_done_evt_i,
    output logic                  irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // State and wires

    leir_state_t st;
    leir_state_t next_st;

    leir_tr_t    set_tr;
    leir_al_t    set_al;
    leir_in_t    set_in;
    leir_tr_t    clr_tr;
    leir_al_t    clr_al;
    leir_in_t    clr_in;
    leir_tr_t    pend_tr;
    leir_al_t    pend_al;
    leir_in_t    pend_in;

    logic                   req;
    logic                   wr_commit;
    logic                   lane0;
    logic [`LEIR_IDX_W-1:0] idx;
    leir_byte_t             wbyte;
    leir_byte_t             rbyte;
    logic                   hit_pend_tr;
    logic                   hit_pend_al;
    logic                   hit_pend_in;
    logic                   hit_en_tr;
    logic                   hit_en_al;
    logic                   hit_en_in;
    logic                   any_active;

    ////////////////////////////////////////////////////////////////////////
    // Bus request decode

    assign req       = wb_cyc_i & wb_stb_i;
    assign lane0     = wb_sel_i[0];
    assign idx       = wb_adr_i[`LEIR_IDX_LSB +: `LEIR_IDX_W];
    assign wbyte     = wb_dat_i[`LEIR_DATA_W-1:0];
    assign wr_commit = req & wb_we_i & st.ack & lane0;

    always_comb begin
        hit_pend_tr = 1'b0;
        hit_pend_al = 1'b0;
        hit_pend_in = 1'b0;
        hit_en_tr   = 1'b0;
        hit_en_al   = 1'b0;
        hit_en_in   = 1'b0;
        if (idx == `LEIR_IDX_PEND_TR) begin
            hit_pend_tr = 1'b1;
        end else if (idx == `LEIR_IDX_PEND_AL) begin
            hit_pend_al = 1'b1;
        end else if (idx == `LEIR_IDX_PEND_IN) begin
            hit_pend_in = 1'b1;
        end else if (idx == `LEIR_IDX_EN_TR) begin
            hit_en_tr = 1'b1;
        end else if (idx == `LEIR_IDX_EN_AL) begin
            hit_en_al = 1'b1;
        end else if (idx == `LEIR_IDX_EN_IN) begin
            hit_en_in = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event to flag mapping

    always_comb begin
        set_tr = `LEIR_RST_TR;
        set_tr[`LEIR_TR_RING_OFF] = ring_cadence_off_evt_i;
        set_tr[`LEIR_TR_RING_ON]  = ring_cadence_on_evt_i;
        set_tr[`LEIR_TR_TWO_OFF]  = tone_gen_two_off_evt_i;
        set_tr[`LEIR_TR_TWO_ON]   = tone_gen_two_on_evt_i;
        set_tr[`LEIR_TR_ONE_OFF]  = tone_gen_one_off_evt_i;
        set_tr[`LEIR_TR_ONE_ON]   = tone_gen_one_on_evt_i;
    end

    always_comb begin
        set_al = `LEIR_RST_AL;
        set_al[`LEIR_AL_SIX]   = power_alarm_six_evt_i;
        set_al[`LEIR_AL_FIVE]  = power_alarm_five_evt_i;
        set_al[`LEIR_AL_FOUR]  = power_alarm_four_evt_i;
        set_al[`LEIR_AL_THREE] = power_alarm_three_evt_i;
        set_al[`LEIR_AL_TWO]   = power_alarm_two_evt_i;
        set_al[`LEIR_AL_ONE]   = power_alarm_one_evt_i;
        set_al[`LEIR_AL_HOOK]  = hook_change_evt_i;
        set_al[`LEIR_AL_RING_ANSWER] = ring_answer_evt_i;
    end

    assign set_in = indirect_done_evt_i;

    ////////////////////////////////////////////////////////////////////////
    // Write-one-to-clear strobes

    always_comb begin
        clr_tr = `LEIR_RST_TR;
        clr_al = `LEIR_RST_AL;
        clr_in = `LEIR_RST_IN;
        if (wr_commit && hit_pend_tr) begin
            clr_tr = wbyte[`LEIR_TR_W-1:0];
        end
        if (wr_commit && hit_pend_al) begin
            clr_al = wbyte[`LEIR_AL_W-1:0];
        end
        if (wr_commit && hit_pend_in) begin
            clr_in = wbyte[`LEIR_IN_DONE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending flag banks

    leir_flag_bank #(
        .W       (`LEIR_TR_W)
    ) u_pend_tr (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (set_tr),
        .clr_i   (clr_tr),
        .flags_o (pend_tr)
    );

    leir_flag_bank #(
        .W       (`LEIR_AL_W)
    ) u_pend_al (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (set_al),
        .clr_i   (clr_al),
        .flags_o (pend_al)
    );

    leir_flag_bank #(
        .W       (`LEIR_IN_W)
    ) u_pend_in (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (set_in),
        .clr_i   (clr_in),
        .flags_o (pend_in)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data assembly

    always_comb begin
        rbyte = `LEIR_ZERO_BYTE;
        if (hit_pend_tr) begin
            rbyte[`LEIR_TR_W-1:0] = pend_tr;
        end else if (hit_pend_al) begin
            rbyte = pend_al;
        end else if (hit_pend_in) begin
            rbyte[`LEIR_IN_DONE] = pend_in[0];
        end else if (hit_en_tr) begin
            rbyte[`LEIR_TR_W-1:0] = st.en_tr;
        end else if (hit_en_al) begin
            rbyte = st.en_al;
        end else if (hit_en_in) begin
            rbyte[`LEIR_IN_DONE] = st.en_in[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt combine

    assign any_active = |(pend_tr & st.en_tr)
                      | |(pend_al & st.en_al)
                      | |(pend_in & st.en_in);

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st = st;
        next_st.ack = req & ~st.ack;
        next_st.irq = any_active;
        if (req && !st.ack) begin
            next_st.rdat = wb_we_i ? `LEIR_ZERO_BYTE : rbyte;
        end
        if (wr_commit && hit_en_tr) begin
            next_st.en_tr = wbyte[`LEIR_TR_W-1:0];
        end
        if (wr_commit && hit_en_al) begin
            next_st.en_al = wbyte[`LEIR_AL_W-1:0];
        end
        if (wr_commit && hit_en_in) begin
            next_st.en_in = wbyte[`LEIR_IN_DONE];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.en_tr <= `LEIR_RST_TR;
            st.en_al <= `LEIR_RST_AL;
            st.en_in <= `LEIR_RST_IN;
            st.ack   <= 1'b0;
            st.rdat  <= `LEIR_RST_BYTE;
            st.irq   <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign wb_ack_o = st.ack;
    assign wb_dat_o = {`LEIR_ZERO_UPPER, st.rdat};
    assign irq_o    = st.irq;

endmodule : leir_top

/* bench/leir_top_props.sv */
// Concurrent checks on the line event interrupt register ports
`timescale 1ns/1ps
`include "leir_regs.svh"

module leir_top_props
    import leir_pkg::*;
#(
    parameter int ADR_W = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]      wb_dat_o,
    input  wire logic             wb_ack_o,
    input  wire logic             hook_change_evt_i,
    input  wire logic             ring_answer_evt_i,
    input  wire logic             irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic       rd;
    logic [5:0] ix;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign ix = wb_adr_i[7:2];

    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle");
    property p_upper;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper data set");
    property p_res1;
        rd && (ix == `LEIR_IDX_PEND_TR || ix == `LEIR_IDX_EN_TR)
            |=> wb_dat_o[7:6] == 2'h0;
    endproperty
    a_res1: assert property (p_res1) else $error("bits 7:6 set");
    property p_res3;
        rd && (ix == `LEIR_IDX_PEND_IN || ix == `LEIR_IDX_EN_IN)
            |=> {wb_dat_o[7:2], wb_dat_o[0]} == 7'h00;
    endproperty
    a_res3: assert property (p_res3) else $error("spare bits set");
    property p_hook;
        !$past(rst_i) && $past(hook_change_evt_i) && rd
            && ix == `LEIR_IDX_PEND_AL |=> wb_dat_o[1];
    endproperty
    a_hook: assert property (p_hook) else $error("hook flag lost");
    property p_ring;
        !$past(rst_i) && $past(ring_answer_evt_i) && rd
            && ix == `LEIR_IDX_PEND_AL |=> wb_dat_o[0];
    endproperty
    a_ring: assert property (p_ring) else $error("ring flag lost");
    property p_fell;
        $fell(irq_o) |-> $past(wb_ack_o && wb_we_i, 2);
    endproperty
    a_fell: assert property (p_fell) else $error("irq fell alone");
    property p_rst;
        $past(rst_i) |-> !wb_ack_o && !irq_o;
    endproperty
    a_rst: assert property (p_rst) else $error("busy after reset");
endmodule : leir_top_props

bind leir_top leir_top_props #(.ADR_W(ADR_W)) u_props (.*);

/* bench/leir_top_tb_top.sv */
// Self-checking bench for the line event interrupt registers
`timescale 1ns/1ps
`include "leir_regs.svh"

module leir_top_tb_top
    import leir_pkg::*;
;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        irq_o;
    logic [14:0] ev       = 15'h0000;
    logic [31:0] v;
    leir_byte_t  s1, s2, s3, e1, e2, e3;
    logic [31:0] exp_q[$];
    int          fail_count  = 0;
    int          comparisons = 0;
    int          seed        = 91035;
    logic [7:0]  all [8] = '{8'h48, 8'h4C, 8'h50, 8'h54,
                             8'h58, 8'h5C, 8'h00, 8'h60};

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    leir_top DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_o(irq_o),
        .ring_cadence_off_evt_i(ev[14]), .ring_cadence_on_evt_i(ev[13]),
        .tone_gen_two_off_evt_i(ev[12]), .tone_gen_two_on_evt_i(ev[11]),
        .tone_gen_one_off_evt_i(ev[10]), .tone_gen_one_on_evt_i(ev[9]),
        .power_alarm_six_evt_i(ev[8]), .power_alarm_five_evt_i(ev[7]),
        .power_alarm_four_evt_i(ev[6]), .power_alarm_three_evt_i(ev[5]),
        .power_alarm_two_evt_i(ev[4]), .power_alarm_one_evt_i(ev[3]),
        .hook_change_evt_i(ev[2]), .ring_answer_evt_i(ev[1]),
        .indirect_done_evt_i(ev[0])
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] model(input logic [7:0] ad);
        case (ad[7:2])
            `LEIR_IDX_PEND_TR: model = {24'h000000, s1};
            `LEIR_IDX_PEND_AL: model = {24'h000000, s2};
            `LEIR_IDX_PEND_IN: model = {24'h000000, s3};
            `LEIR_IDX_EN_TR:   model = {24'h000000, e1};
            `LEIR_IDX_EN_AL:   model = {24'h000000, e2};
            `LEIR_IDX_EN_IN:   model = {24'h000000, e3};
            default:           model = 32'h00000000;
        endcase
    endfunction : model

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic results();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic wb(input logic we, input logic [7:0] ad,
                      input logic [3:0] sl, input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= ad;
        wb_sel_i <= sl;
        wb_dat_i <= {24'h000000, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50) begin
            fail_count++;
            results();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        ev       <= 15'h0000;
        @(posedge clk_i);
    endtask : wb

    task automatic rd(input logic [7:0] ad);
        exp_q.push_back(model(ad));
        wb(1'b0, ad, 4'hF, 8'h00);
    endtask : rd

    task automatic wr(input logic [7:0] ad, input logic [3:0] sl,
                      input logic [7:0] d);
        if (sl[0]) begin
            case (ad[7:2])
                `LEIR_IDX_PEND_TR: s1 = s1 & ~d;
                `LEIR_IDX_PEND_AL: s2 = s2 & ~d;
                `LEIR_IDX_PEND_IN: s3 = s3 & ~d;
                `LEIR_IDX_EN_TR:   e1 = d & 8'h3F;
                `LEIR_IDX_EN_AL:   e2 = d;
                `LEIR_IDX_EN_IN:   e3 = d & 8'h02;
                default: ;
            endcase
        end
        wb(1'b1, ad, sl, d);
    endtask : wr

    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            check(wb_dat_o, exp_q.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {s1, s2, s3, e1, e2, e3} = 48'h0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (all[i]) rd(all[i]);
        for (int i = 3; i < 6; i++) begin
            wr(all[i], 4'h1, 8'hFF);
            rd(all[i]);
        end
        wr(all[4], 4'hE, 8'h00);
        rd(all[4]);
        for (int k = 0; k < 30; k++) begin
            v = $random(seed);
            ev <= v[14:0];
            s1 = s1 | v[14:9];
            s2 = s2 | v[8:1];
            s3 = s3 | {v[0], 1'b0};
            @(posedge clk_i);
            ev <= 15'h0000;
            rd(all[k % 3]);
            v = $random(seed);
            wr(all[(k + 1) % 3], 4'h1, v[7:0]);
            wr(all[3 + k % 3], 4'h1, v[15:8]);
            for (int j = 0; j < 3; j++) rd(all[j]);
            check({31'h0, irq_o}, {31'h0, |{s1 & e1, s2 & e2, s3 & e3}});
        end
        wr(all[7], 4'h1, 8'hFF);
        rd(all[6]);
        rd(all[7]);
        rd(all[1]);
        rd(all[4]);
        for (int j = 0; j < 3; j++) wr(all[j], 4'h1, 8'hFF);
        @(posedge clk_i);
        check({31'h0, irq_o}, 32'h00000000);
        ev <= 15'h0004;
        wr(all[1], 4'h1, 8'h02);
        s2 = s2 | 8'h02;
        rd(all[1]);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        {s1, s2, s3, e1, e2, e3} = 48'h0;
        @(posedge clk_i);
        check({31'h0, irq_o}, 32'h00000000);
        rd(all[1]);
        rd(all[4]);
        results();
    end

    initial begin
        #40000;
        fail_count++;
        results();
    end
endmodule : leir_top_tb_top
